// [bench/fpe_engine_monitor.sv]
// fpe_engine_monitor.sv - port level assertions bound to the page ecc engine
`timescale 1ns/1ns
`default_nettype none
module fpe_engine_monitor #(
   parameter int SECTORS = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // command
   input wire logic op_start,
   input wire logic op_load,
   input wire logic op_boot,
   input wire logic cfg_ecc_bypass,
   input wire logic op_busy,
   input wire logic op_done,
   // streams
   input wire logic src_ready,
   input wire logic dst_valid,
   input wire logic dst_ready,
   input wire logic [15:0] dst_data,
   // result
   input wire logic res_valid,
   input wire logic res_boot,
   input wire fpe_pkg::fpe_class_t res_main_class,
   input wire logic [11:0] res_main_pos
);
   logic [2:0] mode_ff; // {boot, load, bypass} of the running operation

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // remember what the accepted command asked for, so results can be judged at done
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff <= 3'h0;
      end else if (op_start && !op_busy) begin
         mode_ff <= {op_boot, op_load, cfg_ecc_bypass};
      end
   end

   AST_DONE_PULSE: assert property (op_done |=> !op_done)
      else $error("done pulse longer than one cycle");
   AST_START_BUSY: assert property (op_start && !op_busy |=> op_busy)
      else $error("accepted start did not raise busy");
   AST_IDLE_REFUSE: assert property (!op_busy |-> !src_ready)
      else $error("source taken while idle");
   AST_LOAD_DROPS: assert property (op_start && !op_busy && op_load |=> !res_valid)
      else $error("result valid kept across a new load");
   AST_LOAD_VALID: assert property (op_done && mode_ff[1:0] == 2'h2 |-> res_valid)
      else $error("checked load ended without valid result");
   AST_BYPASS_INVALID: assert property (op_done && mode_ff[1:0] == 2'h3
      |-> !res_valid && res_main_pos == 12'h000)
      else $error("bypass load left a valid result or position");
   AST_BOOT_FLAG: assert property (op_done && mode_ff[1] |-> res_boot == mode_ff[2])
      else $error("boot flag does not follow the finished load");
   AST_DST_HOLD: assert property (dst_valid && !dst_ready |=> dst_valid && $stable(dst_data))
      else $error("sink word changed while stalled");
   AST_NO_ERR_POS: assert property (op_done && mode_ff[1] &&
      res_main_class == fpe_pkg::FPE_NO_ERR |-> res_main_pos == 12'h000)
      else $error("position reported without error");

   // main scenarios reached
   COV_ONE_BIT: cover property (op_done && res_main_class == fpe_pkg::FPE_ONE_BIT);
   COV_TWO_BIT: cover property (op_done && res_main_class == fpe_pkg::FPE_TWO_BIT);
   COV_BYPASS_LOAD: cover property (op_done && mode_ff[1:0] == 2'h3);
endmodule // fpe_engine_monitor

bind fpe_engine fpe_engine_monitor #(.SECTORS(SECTORS)) u_fpe_engine_monitor (
   .clk, .reset_n, .op_start, .op_load, .op_boot, .cfg_ecc_bypass, .op_busy, .op_done,
   .src_ready, .dst_valid, .dst_ready, .dst_data, .res_valid, .res_boot,
   .res_main_class, .res_main_pos
);
`default_nettype wire

// [bench/fpe_engine_tb.sv]
// fpe_engine_tb.sv - scenario testbench of the page ecc engine, one sector per operation
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module fpe_engine_tb;
   localparam int FW = 264;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic op_start = 1'b0;
   logic op_load = 1'b0;
   logic op_boot = 1'b0;
   logic cfg_ecc_bypass = 1'b0;
   logic src_valid = 1'b0;
   logic [15:0] src_data = 16'h0000;
   logic sink_clr = 1'b0;
   logic sink_slow = 1'b0;
   logic op_busy, op_done, src_ready, dst_valid, dst_ready, res_valid, res_boot;
   logic [15:0] dst_data;
   fpe_pkg::fpe_class_t res_main_class, res_spare_class;
   logic [11:0] res_main_pos;
   logic [4:0] res_spare_pos;
   logic [15:0] fr [FW];
   logic [15:0] ex [FW];
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   fpe_engine #(.SECTORS(1)) u_fpe_engine (
      .clk(clk), .reset_n(reset_n), .op_start(op_start), .op_load(op_load),
      .op_boot(op_boot), .cfg_ecc_bypass(cfg_ecc_bypass), .op_busy(op_busy),
      .op_done(op_done), .src_valid(src_valid), .src_ready(src_ready),
      .src_data(src_data), .dst_valid(dst_valid), .dst_ready(dst_ready),
      .dst_data(dst_data), .res_valid(res_valid), .res_boot(res_boot),
      .res_main_class(res_main_class), .res_spare_class(res_spare_class),
      .res_main_pos(res_main_pos), .res_spare_pos(res_spare_pos)
   );

   fpe_sink_model u_fpe_sink_model (
      .clk(clk), .reset_n(reset_n), .clr(sink_clr), .slow(sink_slow),
      .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data)
   );

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // a hang ends the run as a failure
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end

   // raw frame in fr; ex gets the same frame with the codes worked out from the data
   task automatic build();
      logic [23:0] mc;
      logic [9:0] sc;
      logic [11:0] a;
      logic [4:0] s;
      mc = 24'h000000;
      sc = 10'h000;
      for (int w = 0; w < FW; w++) fr[w] = 16'(w * 16'h9E37) ^ 16'h5A0F;
      for (int w = 0; w < 256; w++) for (int b = 0; b < 16; b++) if (fr[w][b]) begin
         a = {w[7:0], b[3:0]};
         mc ^= {~a, a};
      end
      for (int k = 1; k < 3; k++) for (int b = 0; b < 16; b++) if (fr[256+k][b]) begin
         s = {k == 2, b[3:0]};
         sc ^= {~s, s};
      end
      ex = fr;
      ex[261] = mc[15:0];
      ex[262] = {8'hFF, mc[23:16]};
      ex[263] = {6'h3F, sc};
   endtask

   // one whole operation: feed fr in order, wait for done and for the sink to hold all words
   task automatic run_op(input logic ld, input logic bt, input logic byp, input logic slw);
      int i;
      int guard;
      i = 0;
      guard = 0;
      sink_clr <= 1'b1;
      sink_slow <= slw;
      op_start <= 1'b1;
      op_load <= ld;
      op_boot <= bt;
      cfg_ecc_bypass <= byp;
      src_valid <= 1'b1;
      src_data <= fr[0];
      while (i < FW && guard < 4000) begin
         @(posedge clk);
         sink_clr <= 1'b0;
         op_start <= 1'b0;
         guard++;
         if (src_ready) begin
            i++;
            if (i < FW) src_data <= fr[i];
            else src_valid <= 1'b0;
         end
      end
      while (!op_done && guard < 4000) begin
         @(posedge clk);
         guard++;
      end
      while (u_fpe_sink_model.cnt < FW && guard < 4000) begin
         @(posedge clk);
         guard++;
      end
      // a guard that ran out is a hang of this operation and counts as a mismatch
      `CHK(guard < 4000, 1'b1)
      repeat (2) @(posedge clk);
   endtask

   task automatic check_out();
      for (int k = 0; k < FW; k++) `CHK(u_fpe_sink_model.mem[k], ex[k])
   endtask

   task automatic t_program();
      build();
      run_op(1'b0, 1'b0, 1'b0, 1'b1);
      check_out();
   endtask

   task automatic t_load_clean();
      build();
      fr = ex;
      run_op(1'b1, 1'b0, 1'b0, 1'b0);
      check_out();
      `CHK(res_valid, 1'b1)
      `CHK(res_main_class, fpe_pkg::FPE_NO_ERR)
      `CHK(res_spare_class, fpe_pkg::FPE_NO_ERR)
   endtask

   task automatic t_load_single_boot();
      build();
      fr = ex;
      fr[10][3] = ~fr[10][3];
      fr[258][2] = ~fr[258][2];
      run_op(1'b1, 1'b1, 1'b0, 1'b1);
      check_out();
      `CHK(res_main_class, fpe_pkg::FPE_ONE_BIT)
      `CHK(res_spare_class, fpe_pkg::FPE_ONE_BIT)
      `CHK(res_main_pos, 12'h0A3)
      `CHK(res_spare_pos, 5'h12)
      `CHK(res_boot, 1'b1)
   endtask

   task automatic t_load_double();
      build();
      fr = ex;
      fr[20][0] = ~fr[20][0];
      fr[30][7] = ~fr[30][7];
      // a flip inside the stored spare code: reported, nothing to fix in the data
      fr[263][0] = ~fr[263][0];
      run_op(1'b1, 1'b0, 1'b0, 1'b0);
      `CHK(u_fpe_sink_model.mem[20], fr[20])
      `CHK(u_fpe_sink_model.mem[263], fr[263])
      `CHK(res_main_class, fpe_pkg::FPE_TWO_BIT)
      `CHK(res_spare_class, fpe_pkg::FPE_ONE_BIT)
      `CHK(res_spare_pos, 5'h00)
      `CHK(res_boot, 1'b0)
   endtask

   task automatic t_bypass_program();
      build();
      ex = fr;
      run_op(1'b0, 1'b0, 1'b1, 1'b0);
      check_out();
   endtask

   task automatic t_bypass_load();
      build();
      fr = ex;
      fr[10][3] = ~fr[10][3];
      ex = fr;
      run_op(1'b1, 1'b0, 1'b1, 1'b1);
      check_out();
      `CHK(res_valid, 1'b0)
      `CHK(res_main_pos, 12'h000)
   endtask

   // reset, then each scenario in turn
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_program();
      t_load_clean();
      t_load_single_boot();
      t_load_double();
      t_bypass_program();
      t_bypass_load();
      print_verdict();
   end
endmodule // fpe_engine_tb
`default_nettype wire

// [bench/fpe_sink_model.sv]
// fpe_sink_model.sv - behavioural sink standing at the far side of the output stream
`timescale 1ns/1ns
`default_nettype none
module fpe_sink_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // bench control
   input wire logic clr,
   input wire logic slow,
   // word stream
   input wire logic dst_valid,
   output logic dst_ready,
   input wire logic [15:0] dst_data
);
   logic [15:0] mem [264];
   int cnt;

   // slow mode stalls every other cycle so the engine must hold its word
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dst_ready <= 1'b0;
         cnt <= 0;
      end else begin
         dst_ready <= slow ? ~dst_ready : 1'b1;
         if (clr) begin
            cnt <= 0;
         end else if (dst_valid && dst_ready && cnt < 264) begin
            mem[cnt] <= dst_data;
            cnt <= cnt + 1;
         end
      end
   end
endmodule // fpe_sink_model
`default_nettype wire

// [hw/fpe_engine.sv]
// fpe_engine.sv - page ecc engine between the on-chip buffer and the flash page buffer
// What this block does
// R1 - detect two-bit, correct one-bit, main and spare
// R2 - program: 24-bit main, 10-bit spare code
// R3 - load: recompute code, compare with stored
// R4 - fix single flipped bit before buffer sees it
// R5 - status updated automatically after every load
// R6 - outcome: none, one-bit correctable, two-bit
// R7 - load hands stored codes, not fresh ones
// R8 - boot loads checked and corrected likewise
// R9 - bypass: no codes computed, no position
// R10 - bypass program leaves code words untouched
// R11 - bypass load: no check, status invalid
// R12 - configuration bit nine selects bypass mode
// R13 - host need not poll; avoid bypass
`timescale 1ns/1ns
`default_nettype none
`include "fpe_map.svh"
module fpe_engine #(
   parameter int SECTORS = `FPE_SECTORS_DEFAULT
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // operation command
   input wire logic op_start,
   input wire logic op_load,
   input wire logic op_boot,
   input wire logic cfg_ecc_bypass,
   output logic op_busy,
   output logic op_done,
   // word source: buffer memory on program, flash page buffer on load
   input wire logic src_valid,
   output logic src_ready,
   input wire logic [15:0] src_data,
   // word sink: flash page buffer on program, buffer memory on load
   output logic dst_valid,
   input wire logic dst_ready,
   output logic [15:0] dst_data,
   // result of the last load
   output logic res_valid,
   output logic res_boot,
   output fpe_pkg::fpe_class_t res_main_class,
   output fpe_pkg::fpe_class_t res_spare_class,
   output logic [`FPE_MAIN_ADDR_W-1:0] res_main_pos,
   output logic [`FPE_SPARE_ADDR_W-1:0] res_spare_pos
);

   localparam int SW = (SECTORS > 1) ? $clog2(SECTORS) : 1;
   localparam logic [SW-1:0] SEC_LAST = SW'(SECTORS - 1);
   localparam int FRAME = `FPE_IDX_LAST + 1;

   typedef struct packed {
      fpe_pkg::fpe_state_t st;
      logic bypass;
      logic boot;
      logic [8:0] idx;
      logic [SW-1:0] sec;
      logic [`FPE_MAIN_CODE_W-1:0] stored_main;
      logic [`FPE_SPARE_CODE_W-1:0] stored_spare;
      logic out_valid;
      logic [15:0] out_data;
      logic done;
      logic res_valid;
      logic res_boot;
      fpe_pkg::fpe_class_t main_cls;
      fpe_pkg::fpe_class_t spare_cls;
      logic [`FPE_MAIN_ADDR_W-1:0] main_pos;
      logic [`FPE_SPARE_ADDR_W-1:0] spare_pos;
   } fpe_eng_t;

   fpe_eng_t cur_ff;
   fpe_eng_t nxt_cur;

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic [1:0] rst_sync_ff;
   logic rst_n;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   // sector holding store: correction needs the whole sector before release
   logic [15:0] sect_mem [0:FRAME-1];
   logic mem_we;
   logic [8:0] mem_wa;
   logic [15:0] mem_wd;

   always_ff @(posedge clk) begin
      if (mem_we) begin
         sect_mem[mem_wa] <= mem_wd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // code accumulators and error decoders
   logic take;
   logic acc_clr;
   logic main_en;
   logic spare_en;
   logic [`FPE_MAIN_CODE_W-1:0] main_code;
   logic [`FPE_SPARE_CODE_W-1:0] spare_code;
   fpe_pkg::fpe_class_t main_cls;
   fpe_pkg::fpe_class_t spare_cls;
   logic [`FPE_MAIN_ADDR_W-1:0] main_pos;
   logic [`FPE_SPARE_ADDR_W-1:0] spare_pos;
   logic main_fix;
   logic spare_fix;

   fpe_parity_acc #(.AW(`FPE_MAIN_ADDR_W)) u_main_acc (
      .clk(clk),
      .rst_n(rst_n),
      .clr(acc_clr),
      .en(main_en),
      .waddr(cur_ff.idx[7:0]),
      .word(src_data),
      .code(main_code)
   );

   fpe_parity_acc #(.AW(`FPE_SPARE_ADDR_W)) u_spare_acc (
      .clk(clk),
      .rst_n(rst_n),
      .clr(acc_clr),
      .en(spare_en),
      .waddr(cur_ff.idx == `FPE_IDX_SPARE_P1),
      .word(src_data),
      .code(spare_code)
   );

   fpe_syndrome #(.AW(`FPE_MAIN_ADDR_W)) u_main_syn (
      .stored(cur_ff.stored_main),
      .fresh(main_code),
      .cls(main_cls),
      .pos(main_pos),
      .fix(main_fix)
   );

   fpe_syndrome #(.AW(`FPE_SPARE_ADDR_W)) u_spare_syn (
      .stored(cur_ff.stored_spare),
      .fresh(spare_code),
      .cls(spare_cls),
      .pos(spare_pos),
      .fix(spare_fix)
   );

   ////////////////////////////////////////////////////////////////////////////
   // handshakes: the output stage frees when empty or being drained
   logic out_free;
   logic in_frame_main;
   logic in_frame_spare;

   assign out_free = !cur_ff.out_valid || dst_ready;
   assign src_ready = ((cur_ff.st == fpe_pkg::FPE_PROG) && out_free) ||
                      (cur_ff.st == fpe_pkg::FPE_FILL);
   assign take = src_valid && src_ready;
   assign in_frame_main = cur_ff.idx < `FPE_IDX_MAIN_END;
   assign in_frame_spare = (cur_ff.idx == `FPE_IDX_SPARE_P0) ||
                           (cur_ff.idx == `FPE_IDX_SPARE_P1);
   // codes are built in the background of every non-bypass transfer
   assign acc_clr = take && (cur_ff.idx == `FPE_IDX_FIRST);
   assign main_en = take && in_frame_main && !cur_ff.bypass; // R2 R3 R9 R11
   assign spare_en = take && in_frame_spare && !cur_ff.bypass; // R2 R3 R9 R11

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.done = 1'b0;
      mem_we = 1'b0;
      mem_wa = cur_ff.idx;
      mem_wd = src_data;
      if (dst_ready) begin
         nxt_cur.out_valid = 1'b0;
      end
      case (cur_ff.st)
         fpe_pkg::FPE_IDLE: begin
            if (op_start) begin
               // mode is sampled per operation, so a change waits for the next one
               nxt_cur.bypass = cfg_ecc_bypass; // R12
               nxt_cur.boot = op_boot; // R8
               nxt_cur.idx = `FPE_IDX_FIRST;
               nxt_cur.sec = '0;
               if (op_load) begin
                  nxt_cur.st = fpe_pkg::FPE_FILL;
                  nxt_cur.res_valid = 1'b0;
                  nxt_cur.main_cls = fpe_pkg::FPE_NO_ERR;
                  nxt_cur.spare_cls = fpe_pkg::FPE_NO_ERR;
                  nxt_cur.main_pos = '0;
                  nxt_cur.spare_pos = '0;
               end else begin
                  nxt_cur.st = fpe_pkg::FPE_PROG;
               end
            end
         end
         fpe_pkg::FPE_PROG: begin
            if (take) begin
               nxt_cur.out_valid = 1'b1;
               nxt_cur.out_data = src_data;
               // code words are replaced by the engine only when it is active
               if (!cur_ff.bypass) begin // R10
                  if (cur_ff.idx == `FPE_IDX_CODE_LO) begin
                     nxt_cur.out_data = main_code[15:0]; // R2
                  end else if (cur_ff.idx == `FPE_IDX_CODE_HI) begin
                     nxt_cur.out_data = {`FPE_CODE_HI_FILL, main_code[23:16]}; // R2
                  end else if (cur_ff.idx == `FPE_IDX_CODE_SP) begin
                     nxt_cur.out_data = {`FPE_CODE_SP_FILL, spare_code}; // R2
                  end
               end
               nxt_cur.idx = cur_ff.idx + 9'h001;
               if (cur_ff.idx == `FPE_IDX_LAST) begin
                  nxt_cur.idx = `FPE_IDX_FIRST;
                  nxt_cur.sec = cur_ff.sec + 1'b1;
                  if (cur_ff.sec == SEC_LAST) begin
                     nxt_cur.st = fpe_pkg::FPE_IDLE;
                     nxt_cur.done = 1'b1;
                  end
               end
            end
         end
         fpe_pkg::FPE_FILL: begin
            if (take) begin
               mem_we = 1'b1;
               // stored codes stay in the frame untouched and go out as read
               if (cur_ff.idx == `FPE_IDX_CODE_LO) begin
                  nxt_cur.stored_main[15:0] = src_data; // R3 R7
               end else if (cur_ff.idx == `FPE_IDX_CODE_HI) begin
                  nxt_cur.stored_main[23:16] = src_data[7:0]; // R3 R7
               end else if (cur_ff.idx == `FPE_IDX_CODE_SP) begin
                  nxt_cur.stored_spare = src_data[9:0]; // R3 R7
               end
               nxt_cur.idx = cur_ff.idx + 9'h001;
               if (cur_ff.idx == `FPE_IDX_LAST) begin
                  nxt_cur.idx = `FPE_IDX_FIRST;
                  nxt_cur.st = cur_ff.bypass ? fpe_pkg::FPE_DRAIN : fpe_pkg::FPE_FIX_MAIN; // R11
               end
            end
         end
         fpe_pkg::FPE_FIX_MAIN: begin
            // worst outcome over the page is kept; last corrected position wins
            if (main_cls > cur_ff.main_cls) begin
               nxt_cur.main_cls = main_cls; // R5 R6
            end
            if (spare_cls > cur_ff.spare_cls) begin
               nxt_cur.spare_cls = spare_cls; // R5 R6
            end
            if (main_fix) begin
               nxt_cur.main_pos = main_pos;
               mem_we = 1'b1; // R4
               mem_wa = {1'b0, main_pos[11:4]};
               mem_wd = sect_mem[{1'b0, main_pos[11:4]}] ^ (16'h0001 << main_pos[3:0]); // R4
            end
            nxt_cur.st = fpe_pkg::FPE_FIX_SPARE;
         end
         fpe_pkg::FPE_FIX_SPARE: begin
            if (spare_fix) begin
               nxt_cur.spare_pos = spare_pos;
               mem_we = 1'b1; // R1 R4
               mem_wa = `FPE_IDX_SPARE_P0 + {8'h00, spare_pos[4]};
               mem_wd = sect_mem[`FPE_IDX_SPARE_P0 + {8'h00, spare_pos[4]}] ^
                        (16'h0001 << spare_pos[3:0]);
            end
            nxt_cur.st = fpe_pkg::FPE_DRAIN;
         end
         fpe_pkg::FPE_DRAIN: begin
            if (out_free) begin
               nxt_cur.out_valid = 1'b1;
               nxt_cur.out_data = sect_mem[cur_ff.idx];
               nxt_cur.idx = cur_ff.idx + 9'h001;
               if (cur_ff.idx == `FPE_IDX_LAST) begin
                  nxt_cur.idx = `FPE_IDX_FIRST;
                  nxt_cur.sec = cur_ff.sec + 1'b1;
                  nxt_cur.st = fpe_pkg::FPE_FILL;
                  if (cur_ff.sec == SEC_LAST) begin
                     nxt_cur.st = fpe_pkg::FPE_IDLE;
                     nxt_cur.done = 1'b1;
                     // bypass leaves the result marked invalid with no position
                     nxt_cur.res_valid = !cur_ff.bypass; // R5 R9 R11
                     nxt_cur.res_boot = cur_ff.boot; // R8
                  end
               end
            end
         end
         default: begin
            nxt_cur.st = fpe_pkg::FPE_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '{st: fpe_pkg::FPE_IDLE,
                     main_cls: fpe_pkg::FPE_NO_ERR,
                     spare_cls: fpe_pkg::FPE_NO_ERR,
                     default: '0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign op_busy = cur_ff.st != fpe_pkg::FPE_IDLE;
   assign op_done = cur_ff.done;
   assign dst_valid = cur_ff.out_valid;
   assign dst_data = cur_ff.out_data;
   assign res_valid = cur_ff.res_valid;
   assign res_boot = cur_ff.res_boot;
   assign res_main_class = cur_ff.main_cls;
   assign res_spare_class = cur_ff.spare_cls;
   assign res_main_pos = cur_ff.main_pos; // R9
   assign res_spare_pos = cur_ff.spare_pos; // R9

endmodule // fpe_engine
`default_nettype wire

// [hw/fpe_map.svh]
// fpe_map.svh - offsets, field positions, widths and counts of the page ecc engine
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH

// word and code widths
`define FPE_WORD_W 16
`define FPE_MAIN_CODE_W 24
`define FPE_SPARE_CODE_W 10
`define FPE_MAIN_ADDR_W 12
`define FPE_SPARE_ADDR_W 5

// word positions inside one sector frame: 256 main words then 8 spare words
`define FPE_IDX_MAIN_END 9'h100
`define FPE_IDX_SPARE_P0 9'h101
`define FPE_IDX_SPARE_P1 9'h102
`define FPE_IDX_CODE_LO 9'h105
`define FPE_IDX_CODE_HI 9'h106
`define FPE_IDX_CODE_SP 9'h107
`define FPE_IDX_LAST 9'h107
`define FPE_IDX_FIRST 9'h000

// fill patterns of the unused bits of the code words
`define FPE_CODE_HI_FILL 8'hFF
`define FPE_CODE_SP_FILL 6'h3F

// position of the bypass bit in the first system configuration register
`define FPE_CFG_BYPASS_BIT 9

// defaults
`define FPE_SECTORS_DEFAULT 4

`endif

// [hw/fpe_parity_acc.sv]
// fpe_parity_acc.sv - line/column parity accumulator giving a 2*AW bit check code
`timescale 1ns/1ns
`default_nettype none
module fpe_parity_acc #(
   parameter int AW = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // word feed
   input wire logic clr,
   input wire logic en,
   input wire logic [AW-5:0] waddr,
   input wire logic [15:0] word,
   // code: [AW-1:0] parities of set address bits, [2AW-1:AW] of clear ones
   output logic [2*AW-1:0] code
);

   typedef struct packed {
      logic [2*AW-1:0] code;
   } fpe_acc_t;

   fpe_acc_t cur_ff;
   fpe_acc_t nxt_cur;

   ////////////////////////////////////////////////////////////////////////////
   // each data bit goes into one parity of every address-bit pair
   always_comb begin
      logic [AW-1:0] addr;
      logic [2*AW-1:0] acc;
      addr = '0;
      acc = clr ? '0 : cur_ff.code;
      nxt_cur = cur_ff;
      for (int b = 0; b < 16; b++) begin
         addr = {waddr, 4'(b)};
         for (int i = 0; i < AW; i++) begin
            if (addr[i]) begin
               acc[i] = acc[i] ^ word[b];
            end else begin
               acc[AW+i] = acc[AW+i] ^ word[b];
            end
         end
      end
      if (en) begin
         nxt_cur.code = acc;
      end else if (clr) begin
         nxt_cur.code = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign code = cur_ff.code;

endmodule // fpe_parity_acc
`default_nettype wire

// [hw/fpe_pkg.sv]
// fpe_pkg.sv - types shared by the page ecc engine files
package fpe_pkg;

   // engine sequencer states
   typedef enum logic [2:0] {
      FPE_IDLE,
      FPE_PROG,
      FPE_FILL,
      FPE_FIX_MAIN,
      FPE_FIX_SPARE,
      FPE_DRAIN
   } fpe_state_t;

   // error outcome, ordered by severity
   typedef enum logic [1:0] {
      FPE_NO_ERR,
      FPE_ONE_BIT,
      FPE_TWO_BIT
   } fpe_class_t;

endpackage

// [hw/fpe_syndrome.sv]
// fpe_syndrome.sv - compares stored and fresh codes and classifies the error
`timescale 1ns/1ns
`default_nettype none
module fpe_syndrome #(
   parameter int AW = 12
) (
   // codes
   input wire logic [2*AW-1:0] stored,
   input wire logic [2*AW-1:0] fresh,
   // outcome
   output fpe_pkg::fpe_class_t cls,
   output logic [AW-1:0] pos,
   output logic fix
);

   logic [2*AW-1:0] syn;
   logic [AW-1:0] odd_half;
   logic [AW-1:0] even_half;

   assign syn = stored ^ fresh;
   assign odd_half = syn[AW-1:0];
   assign even_half = syn[2*AW-1:AW];

   ////////////////////////////////////////////////////////////////////////////
   // one flipped data bit makes every pair disagree; the set half is its address
   always_comb begin
      cls = fpe_pkg::FPE_NO_ERR;
      pos = '0;
      fix = 1'b0;
      if (syn == '0) begin
         cls = fpe_pkg::FPE_NO_ERR;
      end else if ((odd_half ^ even_half) == '1) begin
         cls = fpe_pkg::FPE_ONE_BIT; // R1
         pos = odd_half;
         fix = 1'b1;
      end else if ((syn & (syn - 1'b1)) == '0) begin
         // a flip inside the stored code itself: data is good, nothing to fix
         cls = fpe_pkg::FPE_ONE_BIT;
      end else begin
         cls = fpe_pkg::FPE_TWO_BIT; // R1
      end
   end

endmodule // fpe_syndrome
`default_nettype wire
